// ### rtl/hbdp_pkg.sv
package hbdp_pkg;
  // register window and decode
  localparam int          ADDR_W          = 16;               // host address width
  localparam logic [11:0] BASE_MATCH      = 12'h030;          // decoded base on bits 15..4
  localparam logic [3:0]  OFS_DATA        = 4'h8;             // data register offset
  localparam logic [3:0]  OFS_DWORD_C     = 4'hc;             // doubleword slot holding page select
  localparam logic [3:0]  OFS_PAGE        = 4'hf;             // page select register offset
  localparam logic [7:0]  PAGE_RST        = 8'h00;            // page select after reset
  localparam logic [7:0]  PAGE_HI_RST     = 8'h33;            // fixed upper byte read beside page select
  // timing
  localparam int          CLK_MHZ         = 40;               // core clock rate
  localparam int          DMA_MHZ         = 50;               // memory path rate of the dma engine
  localparam int          RDY_HOLD_CYC    = 1;                // cycles ready stays low at least
  // fifo shape
  localparam int          FIFO_W          = 32;               // fifo word width
  localparam int          FIFO_D          = 16;               // fifo depth
  localparam int          RAM_WORDS       = 2048;             // packet ram words (8 kbyte)
  localparam int          RAM_AW          = 11;               // packet ram address width
  // arbiter grant owner
  typedef enum logic [1:0] {HBDP_OWN_HOST, HBDP_OWN_TX, HBDP_OWN_RX} hbdp_own_t;
  // host cycle state
  typedef enum logic [1:0] {HBDP_IDLE, HBDP_WAIT, HBDP_DONE} hbdp_state_t;
endpackage

// ### rtl/hbdp_fifo.sv
`timescale 1ns/100ps
module hbdp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_ce,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  output logic [WIDTH-1:0]      o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];             // storage
  logic [AW-1:0]    wr_ptr, rd_ptr;          // pointers
  logic [AW:0]      count;                   // fill level
  logic [AW-1:0]    next_wr_ptr, next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push, pop;
  // honest flags
  assign o_ready = (count != DEPTH[AW:0]);
  assign o_valid = (count != '0);
  assign o_data  = mem[rd_ptr];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  // next pointers
  always_comb
  begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end
  // register pointers and storage
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else if (i_ce)
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
      if (push)
        mem[wr_ptr] <= i_data;
    end
  end
endmodule // hbdp_fifo

// ### rtl/hbdp_port.sv
`timescale 1ns/100ps
// Overview of operation
// - select from address 15..4 and enable
// - latch address while strobe low, hold after
// - any width; dword at C writes page only
// - no lane byte swapping, no 8-bit mode
// - swap doubleword halves by address bit 1
// - async ready drops on strobe, clock releases
// - sync mode drives ready from core clock
// - data-path select bypasses decode and paging
// - data-path select in burst or async cycles
// - dma acknowledge drives data-path select for bursts
// - arbiter serialises host and dma ram access
// - ram reads 32 bits, steered by address
// - data register backed by two fifos
// - not ready when fifo cannot serve cycle
// - separate tx/rx counters, alternate when both
// - dma pairs two 16-bit words per cycle
module hbdp_port
  import hbdp_pkg::*;
#(
  parameter int ADDR_WIDTH = hbdp_pkg::ADDR_W
) (
  input  wire logic                  i_clk,              // core clock
  input  wire logic                  i_sys_rst,          // sync reset
  input  wire logic                  i_ce,               // clock enable
  input  wire logic [ADDR_WIDTH-1:0] i_addr,             // host address
  input  wire logic                  i_addr_en,          // address enable, high blocks decode
  input  wire logic                  i_addr_strobe_n,    // address strobe
  input  wire logic                  i_read_strobe_n,    // async read strobe
  input  wire logic                  i_write_strobe_n,   // async write strobe
  input  wire logic [3:0]            i_byte_en_n,        // byte lane enables
  input  wire logic                  i_local_bus_clock,  // sync bus clock, sampled
  input  wire logic                  i_cycle_valid_n,    // sync cycle marker
  input  wire logic                  i_write_not_read,   // sync direction
  input  wire logic                  i_sync_bus_select_n,// low picks sync mode
  input  wire logic                  i_data_path_select_n,// data-path select / dma ack
  input  wire logic [31:0]           i_data,             // host write data
  output logic [31:0]                o_data,             // host read data
  output logic                       o_data_oe,          // data bus drive enable
  output logic                       o_async_ready,      // async ready
  output logic                       o_sync_ready_n,     // sync ready
  input  wire logic [15:0]           i_tx_word,          // mac tx fifo request source (unused data)
  output logic [15:0]                o_tx_word,          // word toward mac transmit
  output logic                       o_tx_valid,         // tx word valid
  input  wire logic                  i_tx_ready,         // mac takes tx word
  input  wire logic [15:0]           i_rx_word,          // word from mac receive
  input  wire logic                  i_rx_valid,         // rx word valid
  output logic                       o_rx_ready,         // rx word accepted
  output logic [7:0]                 o_bank_page_select  // page select value
);
  import hbdp_pkg::*;
  // three-stage samplers for pin inputs
  logic [2:0] s_as, s_rd, s_wr, s_local_bus_clock, s_cyc, s_dcs;
  logic       as_n, rd_n, wr_n, local_bus_clock, cyc_n, dcs_n, local_bus_clock_d;
  logic [ADDR_WIDTH-1:0] a_latch, next_a_latch;     // address latch
  logic [7:0]  bank_page_select, next_page;         // page select register
  logic [RAM_AW-1:0] host_ptr, next_host_ptr;       // host ram pointer
  logic [RAM_AW-1:0] tx_ptr, rx_ptr, next_tx_ptr, next_rx_ptr; // dma counters
  logic [31:0] ram [RAM_WORDS];                     // packet ram
  logic [31:0] rd_word, next_rd_word;               // ram read latch
  hbdp_state_t state, next_state;                   // host cycle state
  hbdp_own_t   own, next_own;                       // last grant
  logic        last_tx, next_last_tx;               // alternation bit
  logic        async_ready, next_async_ready, srdy_n, next_srdy_n;
  logic [31:0] dout, next_dout;
  logic        doe, next_doe;
  logic [15:0] rx_half, next_rx_half;               // first rx half
  logic        rx_have, next_rx_have;
  logic [15:0] tx_half, next_tx_half;               // tx half on offer
  logic        tx_have, next_tx_have;
  // the low half of a fetched word goes out first, then the high half
  logic        tx_hi, next_tx_hi;                   // high half on offer
  // the host read stream keeps its own pointer so it trails receive
  logic [RAM_AW-1:0] hrd_ptr, next_hrd_ptr;         // host read pointer
  // host data fifos
  logic [31:0] wf_dout, rf_din, rf_dout;
  logic        wf_push, wf_rdy, wf_val, wf_pop, rf_push, rf_rdy, rf_val, rf_pop;
  logic        hit, sel_data, strobe, wr_cyc, sync_start, async_start, start;
  logic        rx_req, tx_req, host_req;

  // lane swap for 16-bit hosts by address bit 1
  function automatic logic [31:0] hbdp_swap(input logic [31:0] d, input logic a1);
    hbdp_swap = a1 ? {d[15:0], d[31:16]} : d;
  endfunction

  // sample pins: second and third stage agreeing makes a change
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      s_as <= 3'h7; s_rd <= 3'h7; s_wr <= 3'h7; s_local_bus_clock <= 3'h0; s_cyc <= 3'h7; s_dcs <= 3'h7;
      as_n <= 1'b1; rd_n <= 1'b1; wr_n <= 1'b1; local_bus_clock <= 1'b0; cyc_n <= 1'b1; dcs_n <= 1'b1;
      local_bus_clock_d <= 1'b0;
    end
    else if (i_ce)
    begin
      s_as   <= {s_as[1:0], i_addr_strobe_n};
      s_rd   <= {s_rd[1:0], i_read_strobe_n};
      s_wr   <= {s_wr[1:0], i_write_strobe_n};
      s_local_bus_clock <= {s_local_bus_clock[1:0], i_local_bus_clock};
      s_cyc  <= {s_cyc[1:0], i_cycle_valid_n};
      s_dcs  <= {s_dcs[1:0], i_data_path_select_n};
      if (s_as[2] == s_as[1]) as_n <= s_as[2];
      if (s_rd[2] == s_rd[1]) rd_n <= s_rd[2];
      if (s_wr[2] == s_wr[1]) wr_n <= s_wr[2];
      if (s_local_bus_clock[2] == s_local_bus_clock[1]) local_bus_clock <= s_local_bus_clock[2];
      if (s_cyc[2] == s_cyc[1]) cyc_n <= s_cyc[2];
      if (s_dcs[2] == s_dcs[1]) dcs_n <= s_dcs[2];
      local_bus_clock_d <= local_bus_clock;
    end
  end

  // decode and cycle start
  always_comb
  begin
    hit         = (a_latch[15:4] == BASE_MATCH) && !i_addr_en;
    sel_data    = !dcs_n || (hit && a_latch[3:0] == OFS_DATA);
    // the host never overlaps sync and async; sync select low masks the strobes, so only sync starts
    async_start = (!rd_n || !wr_n) && i_sync_bus_select_n;
    sync_start  = !i_sync_bus_select_n && !cyc_n && local_bus_clock && !local_bus_clock_d;
    // data-path select may start either kind, via dma ack
    start       = (async_start || sync_start) && (state == HBDP_IDLE) && (hit || !dcs_n);
    wr_cyc      = async_start ? !wr_n : i_write_not_read;
    strobe      = !rd_n || !wr_n || !cyc_n;
  end

  // address latch transparent on strobe low with both strobes high
  always_comb
  begin
    next_a_latch = a_latch;
    if (!as_n && rd_n && wr_n)
      next_a_latch = i_addr;
  end

  // data fifos: host writes go in write fifo, read fifo feeds host
  hbdp_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_wfifo (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
    .i_data(hbdp_swap(i_data, a_latch[1])), .i_valid(wf_push), .o_ready(wf_rdy),
    .o_data(wf_dout), .o_valid(wf_val), .i_ready(wf_pop));
  hbdp_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_rfifo (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
    .i_data(rf_din), .i_valid(rf_push), .o_ready(rf_rdy),
    .o_data(rf_dout), .o_valid(rf_val), .i_ready(rf_pop));

  // host cycle engine, ready handling and register access
  always_comb
  begin
    next_state  = state;
    next_async_ready   = async_ready;
    next_srdy_n = 1'b1;
    next_page   = bank_page_select;
    next_dout   = dout;
    next_doe    = doe && strobe;
    wf_push     = 1'b0;
    rf_pop      = 1'b0;
    unique case (state)
      HBDP_IDLE:
      begin
        next_async_ready = 1'b1;
        if (start)
        begin
          // only a strobe cycle may drop async ready; sync cycles leave it high
          next_async_ready  = !async_start;
          next_state = HBDP_WAIT;
        end
      end
      HBDP_WAIT:
      begin
        if (sel_data)
        begin
          // hold not-ready until the fifo can serve the cycle
          if (wr_cyc && wf_rdy)
          begin
            wf_push    = 1'b1;
            next_state = HBDP_DONE;
          end
          else if (!wr_cyc && rf_val)
          begin
            rf_pop     = 1'b1;
            next_dout  = hbdp_swap(rf_dout, a_latch[1]);
            next_doe   = 1'b1;
            next_state = HBDP_DONE;
          end
        end
        else
        begin
          // dword write to C lands only in page select at F
          if (wr_cyc && (a_latch[3:0] == OFS_PAGE ||
              (a_latch[3:0] == OFS_DWORD_C && i_byte_en_n[3] == 1'b0)))
            next_page = i_data[31:24];
          else if (wr_cyc && a_latch[3:0] == 4'he && !i_byte_en_n[1])
            next_page = i_data[15:8];
          if (!wr_cyc)
          begin
            // register reads are word swapped by address bit 1 as well
            next_dout = (a_latch[3:2] == OFS_DWORD_C[3:2]) ?
                        hbdp_swap({bank_page_select, PAGE_HI_RST, 16'h0000},
                                  a_latch[1]) : 32'h0000_0000;
            next_doe  = 1'b1;
          end
          next_state = HBDP_DONE;
        end
      end
      HBDP_DONE:
      begin
        next_async_ready   = 1'b1;
        next_srdy_n = i_sync_bus_select_n;
        if (!strobe)
          next_state = HBDP_IDLE;
        else if (!i_sync_bus_select_n)
          next_state = HBDP_IDLE;
      end
      default: next_state = HBDP_IDLE;
    endcase
  end

  // dma pairing and arbiter requests
  always_comb
  begin
    // rx asks for memory once the second half of a pair is offered
    rx_req   = rx_have && i_rx_valid;
    // tx fetches only words the host has already stored
    tx_req   = !tx_have && (tx_ptr != host_ptr);
    // host asks to store a written word or to prefetch a received one
    host_req = wf_val || (rf_rdy && (hrd_ptr != rx_ptr));
  end

  // arbiter: one ram access per cycle, tx and rx alternate
  always_comb
  begin
    next_own     = own;
    next_last_tx = last_tx;
    next_tx_ptr  = tx_ptr;
    next_rx_ptr  = rx_ptr;
    next_host_ptr = host_ptr;
    next_rd_word = rd_word;
    next_rx_half = rx_half;
    next_rx_have = rx_have;
    next_tx_half = tx_half;
    next_tx_have = tx_have;
    next_tx_hi   = tx_hi;
    next_hrd_ptr = hrd_ptr;
    wf_pop  = 1'b0;
    rf_push = 1'b0;
    // prefetch reads the whole 32-bit word at the host read pointer
    rf_din  = ram[hrd_ptr];
    if (!rx_have && i_rx_valid)
    begin
      next_rx_half = i_rx_word;
      next_rx_have = 1'b1;
    end
    // an accepted low half is followed by the high half of the same word
    if (tx_have && i_tx_ready)
    begin
      if (!tx_hi)
      begin
        next_tx_half = rd_word[31:16];
        next_tx_hi   = 1'b1;
      end
      else
        next_tx_have = 1'b0;
    end
    if ((rx_req || tx_req) && (!host_req || own == HBDP_OWN_HOST))
    begin
      if (rx_req && (!tx_req || last_tx))
      begin
        next_own     = HBDP_OWN_RX;
        next_last_tx = 1'b0;
        next_rx_ptr  = rx_ptr + 1'b1;
        next_rx_have = 1'b0;
      end
      else
      begin
        next_own     = HBDP_OWN_TX;
        next_last_tx = 1'b1;
        next_tx_ptr  = tx_ptr + 1'b1;
        next_rd_word = ram[tx_ptr];
        next_tx_half = ram[tx_ptr][15:0];
        next_tx_have = 1'b1;
        next_tx_hi   = 1'b0;
      end
    end
    else if (host_req)
    begin
      next_own = HBDP_OWN_HOST;
      // stores win over prefetch so written data reaches ram first
      if (wf_val)
      begin
        wf_pop        = 1'b1;
        next_host_ptr = host_ptr + 1'b1;
      end
      else
      begin
        rf_push      = 1'b1;
        next_hrd_ptr = hrd_ptr + 1'b1;
      end
    end
    o_tx_word  = tx_half;
    o_tx_valid = tx_have;
    // the second rx word is taken only in the cycle its pair is stored
    o_rx_ready = !rx_have || (next_rx_ptr != rx_ptr);
  end

  // register all state
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      a_latch <= '0; bank_page_select <= PAGE_RST; state <= HBDP_IDLE; own <= HBDP_OWN_HOST;
      last_tx <= 1'b0; async_ready <= 1'b1; srdy_n <= 1'b1; dout <= '0; doe <= 1'b0;
      host_ptr <= '0; tx_ptr <= '0; rx_ptr <= '0; rd_word <= '0;
      rx_half <= '0; rx_have <= 1'b0; tx_half <= '0; tx_have <= 1'b0;
      tx_hi <= 1'b0;
      hrd_ptr <= '0;
    end
    else if (i_ce)
    begin
      a_latch <= next_a_latch; bank_page_select <= next_page; state <= next_state;
      own <= next_own; last_tx <= next_last_tx; async_ready <= next_async_ready; srdy_n <= next_srdy_n;
      dout <= next_dout; doe <= next_doe; host_ptr <= next_host_ptr;
      tx_ptr <= next_tx_ptr; rx_ptr <= next_rx_ptr; rd_word <= next_rd_word;
      rx_half <= next_rx_half; rx_have <= next_rx_have;
      tx_half <= next_tx_half; tx_have <= next_tx_have;
      tx_hi <= next_tx_hi;
      hrd_ptr <= next_hrd_ptr;
      // store a received pair only in the cycle rx holds the grant
      if (next_rx_ptr != rx_ptr)
        ram[rx_ptr] <= {i_rx_word, rx_half};
      if (wf_pop)
        ram[host_ptr] <= wf_dout;
    end
  end

  // outputs other than o_rx_ready come straight from their registers
  // read data and its drive enable stand until the strobe is released
  // async ready low means the host must extend its cycle
  // sync ready is a single cycle low pulse
  // the page select value is shown for observation
  // hazard: ram is not cleared by reset, so pointers gate every read
  // hazard: tx and host read only behind the matching write pointer
  // limitation: no fill check stops the host overrunning unsent tx data
  // limitation: receive pointer wrapping over unread host data is not caught
  // trade: one ram port per cycle keeps the arbiter a single decision
  // trade: prefetch hides ram latency from host reads of the data register
  // note: pairing keeps the first received word in the low half
  // note: transmit replays the low half before the high half
  // note: a write and a read never share one host pointer
  // note: dma grants alternate between tx and rx when both wait
  // note: the host wins the ram when dma held it last
  // note: swap by address bit 1 serves sixteen bit hosts
  // note: no byte lane swap exists anywhere in the path
  assign o_data             = dout;
  assign o_data_oe          = doe;
  assign o_async_ready      = async_ready;
  assign o_sync_ready_n     = srdy_n;
  assign o_bank_page_select = bank_page_select;
endmodule // hbdp_port

// ### testbench/hbdp_chk.sv
`timescale 1ns/100ps
// pin-level checks of the host port
module hbdp_chk (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_addr_en,
  input wire logic        i_read_strobe_n,
  input wire logic        i_write_strobe_n,
  input wire logic        i_write_not_read,
  input wire logic        i_sync_bus_select_n,
  input wire logic        i_cycle_valid_n,
  input wire logic        i_data_path_select_n,
  input wire logic        i_tx_ready,
  input wire logic        o_data_oe,
  input wire logic        o_async_ready,
  input wire logic        o_sync_ready_n,
  input wire logic        o_tx_valid,
  input wire logic [15:0] o_tx_word,
  input wire logic [7:0]  o_bank_page_select
);
  // one clock domain, reset masks every check
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // reset leaves ready high, bus undriven, page cleared
  property p_rst_val;
    $fell(i_sys_rst) |-> o_bank_page_select == 8'h00 && o_async_ready
      && o_sync_ready_n && !o_data_oe;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("bad values after reset");
  // a cycle not for us never stretches the bus
  property p_unmapped;
    (i_addr_en && i_data_path_select_n)[*6] |-> o_async_ready;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("ready dropped off-chip");
  // ready only falls while a strobe is down
  property p_rdy_cause;
    $fell(o_async_ready) |-> !i_read_strobe_n || !i_write_strobe_n;
  endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("ready fell without strobe");
  // ready comes back once the strobes rest
  property p_rdy_idle;
    (i_read_strobe_n && i_write_strobe_n)[*8] |-> o_async_ready;
  endproperty
  a_rdy_idle: assert property (p_rdy_idle) else $error("ready stuck low");
  // sync ready is a one cycle pulse
  property p_sync_pulse;
    !o_sync_ready_n |=> o_sync_ready_n;
  endproperty
  a_sync_pulse: assert property (p_sync_pulse) else $error("sync ready too long");
  // sync ready only inside a sync cycle
  property p_sync_cause;
    !o_sync_ready_n |-> !i_sync_bus_select_n && !i_cycle_valid_n;
  endproperty
  a_sync_cause: assert property (p_sync_cause) else $error("stray sync ready");
  // no bus drive during a write
  property p_oe_write;
    (!i_write_strobe_n)[*6] |-> !o_data_oe;
  endproperty
  a_oe_write: assert property (p_oe_write) else $error("drive during write");
  // page register moves only on a write
  property p_page_hold;
    (i_write_strobe_n && !i_write_not_read)[*6] |=> $stable(o_bank_page_select);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page moved unasked");
  // stalled transmit word holds still
  property p_tx_hold;
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_word);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx word dropped");
endmodule // hbdp_chk

bind hbdp_port hbdp_chk i_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr_en(i_addr_en),
  .i_read_strobe_n(i_read_strobe_n), .i_write_strobe_n(i_write_strobe_n),
  .i_write_not_read(i_write_not_read), .i_sync_bus_select_n(i_sync_bus_select_n),
  .i_cycle_valid_n(i_cycle_valid_n), .i_data_path_select_n(i_data_path_select_n),
  .i_tx_ready(i_tx_ready), .o_data_oe(o_data_oe), .o_async_ready(o_async_ready),
  .o_sync_ready_n(o_sync_ready_n), .o_tx_valid(o_tx_valid), .o_tx_word(o_tx_word),
  .o_bank_page_select(o_bank_page_select));

// ### testbench/hbdp_host.sv
`timescale 1ns/100ps
// host bus master: async strobes, sync local bus, data-path select
module hbdp_host (
  input  wire logic        i_clk,
  input  wire logic [31:0] i_data,
  input  wire logic        i_async_ready,
  input  wire logic        i_sync_ready_n,
  output logic      [15:0] o_addr,
  output logic             o_addr_en,
  output logic             o_addr_strobe_n,
  output logic             o_read_strobe_n,
  output logic             o_write_strobe_n,
  output logic      [3:0]  o_byte_en_n,
  output logic             o_local_bus_clock,
  output logic             o_cycle_valid_n,
  output logic             o_write_not_read,
  output logic             o_sync_bus_select_n,
  output logic             o_dma_ack_n,
  output logic      [31:0] o_data
);
  // idle bus at time zero
  initial
  begin
    {o_addr, o_addr_en, o_byte_en_n, o_local_bus_clock, o_write_not_read} = '0;
    {o_addr_strobe_n, o_read_strobe_n, o_write_strobe_n} = 3'h7;
    {o_cycle_valid_n, o_sync_bus_select_n, o_dma_ack_n} = 3'h7;
    o_data = 32'h5a5a_a5a5;
  end
  // one bus cycle at a time, never sync and async together
  task automatic acc(input bit sy, input bit wr, input logic [15:0] a, input logic [3:0] be,
                     input logic [31:0] d, input bit dc, output logic [31:0] q, output bit ok);
    int n;
    ok = 0;
    q = '0;
    @(negedge i_clk);
    o_addr = a;
    o_addr_strobe_n = 1'b0;
    o_byte_en_n = dc ? 4'h0 : be; // data-path cycles are whole words
    o_dma_ack_n = ~dc; // acknowledge drives the data-path select
    if (wr)
      o_data = d;
    if (sy)
    begin
      o_sync_bus_select_n = 1'b0;
      o_write_not_read = wr;
      o_cycle_valid_n = 1'b0;
      for (n = 0; n < 64 && !ok; n++)
      begin
        @(negedge i_clk) o_local_bus_clock = n[2]; // 5 MHz local clock
        @(posedge i_clk) if (i_sync_ready_n === 1'b0) {ok, q} = {1'b1, i_data};
      end
    end
    else
    begin
      repeat (4) @(negedge i_clk); // strobe must outlast pin sampling
      o_addr_strobe_n = 1'b1;
      @(negedge i_clk) if (wr) o_write_strobe_n = 1'b0; else o_read_strobe_n = 1'b0;
      for (n = 0; n < 64 && !ok; n++)
        @(posedge i_clk) if (n > 7 && i_async_ready === 1'b1) {ok, q} = {1'b1, i_data};
    end
    // release; data lines show the inverse of the last value
    @(negedge i_clk);
    {o_addr_strobe_n, o_read_strobe_n, o_write_strobe_n, o_cycle_valid_n} = 4'hf;
    {o_sync_bus_select_n, o_dma_ack_n, o_local_bus_clock, o_write_not_read} = 4'hc;
    o_data = ~o_data;
    repeat (4) @(negedge i_clk);
  endtask
endmodule // hbdp_host

// ### testbench/tb.sv
`timescale 1ns/100ps
module tb;
  import hbdp_pkg::*;
  logic        clk, rst, aen, as_n, rd_n, wr_n, local_bus_clock, cyc_n, wnr, sbs_n, dcs_n, ok;
  logic        oe, async_ready, srdy_n, tx_valid, rx_ready;
  logic        tx_ready = 1'b0; // mac transmit side accept
  logic        tx_run   = 1'b0; // lets the mac drain
  logic        rx_valid = 1'b0; // mac receive word offered
  logic [15:0] addr, tx_word, rx_word;
  logic [3:0]  be_n;
  logic [31:0] wdata, rdata, q;
  logic [7:0]  page;
  logic [15:0] txq[$]; // words seen leaving toward the mac
  int          num_errors = 0;
  int          checks = 0;
  int          k;
  hbdp_host i_host (.i_clk(clk), .i_data(rdata), .i_async_ready(async_ready), .i_sync_ready_n(srdy_n),
    .o_addr(addr), .o_addr_en(aen), .o_addr_strobe_n(as_n), .o_read_strobe_n(rd_n),
    .o_write_strobe_n(wr_n), .o_byte_en_n(be_n), .o_local_bus_clock(local_bus_clock),
    .o_cycle_valid_n(cyc_n), .o_write_not_read(wnr), .o_sync_bus_select_n(sbs_n),
    .o_dma_ack_n(dcs_n), .o_data(wdata));
  hbdp_port i_dut (.i_clk(clk), .i_sys_rst(rst), .i_ce(1'b1), .i_addr(addr), .i_addr_en(aen),
    .i_addr_strobe_n(as_n), .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n), .i_byte_en_n(be_n),
    .i_local_bus_clock(local_bus_clock), .i_cycle_valid_n(cyc_n), .i_write_not_read(wnr),
    .i_sync_bus_select_n(sbs_n), .i_data_path_select_n(dcs_n), .i_data(wdata), .o_data(rdata),
    .o_data_oe(oe), .o_async_ready(async_ready), .o_sync_ready_n(srdy_n), .i_tx_word(16'h0000),
    .o_tx_word(tx_word), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .i_rx_word(rx_word),
    .i_rx_valid(rx_valid), .o_rx_ready(rx_ready), .o_bank_page_select(page));
  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // mac stalls every other cycle while draining
  always @(negedge clk) tx_ready <= tx_run & ~tx_ready;
  always @(posedge clk) if (tx_valid === 1'b1 && tx_ready === 1'b1) txq.push_back(tx_word);
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask
  // one host cycle that must finish
  task automatic run(input bit sy, wr, input logic [15:0] a, input logic [3:0] be,
                     input logic [31:0] d, input bit dc);
    i_host.acc(sy, wr, a, be, d, dc, q, ok);
    chk({31'h0, ok}, 32'h1);
  endtask
  // mac hands one receive word
  task automatic send(input logic [15:0] w);
    int n;
    @(negedge clk) {rx_word, rx_valid} = {w, 1'b1};
    for (n = 0; n < 50 && rx_ready !== 1'b1; n++) @(posedge clk);
    @(negedge clk) {rx_word, rx_valid} = {~w, 1'b0};
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // cut a hang short
  initial
  begin
    repeat (30000) @(posedge clk);
    num_errors++;
    summarize();
  end
  initial
  begin
    {rst, rx_word} = {1'b1, 16'h0000};
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk({24'h0, page}, 32'h00);
    run(0, 1, 16'h030c, 4'h0, 32'h7e11_2233, 0);
    chk({24'h0, page}, 32'h7e);
    run(0, 1, 16'h030f, 4'h7, 32'h9100_00a5, 0);
    chk({24'h0, page}, 32'h91);
    run(0, 0, 16'h030e, 4'hc, 32'h0, 0);
    chk({16'h0, q[15:0]}, 32'h9133);
    run(0, 0, 16'h030c, 4'h0, 32'h0, 0);
    chk({16'h0, q[31:16]}, 32'h9133);
    run(0, 1, 16'h040f, 4'h7, 32'h1200_0000, 0);
    i_host.o_addr_en = 1'b1;
    run(0, 1, 16'h030f, 4'h7, 32'h1300_0000, 0);
    i_host.o_addr_en = 1'b0;
    chk({24'h0, page}, 32'h91);
    run(1, 1, 16'h030f, 4'h7, 32'h5c00_0000, 0);
    chk({24'h0, page}, 32'h5c);
    run(1, 0, 16'h030c, 4'h0, 32'h0, 0);
    chk({16'h0, q[31:16]}, 32'h5c33);
    fork
      run(0, 0, 16'h0308, 4'h0, 32'h0, 0);
      begin
        repeat (20) @(negedge clk);
        chk({31'h0, async_ready}, 32'h0);
        send(16'hbeef);
        send(16'hcafe);
      end
    join
    chk(q, 32'hcafe_beef);
    send(16'h1234);
    send(16'h5678);
    run(0, 0, 16'h0000, 4'h0, 32'h0, 1);
    chk(q, 32'h5678_1234);
    for (k = 0; k < 20; k++)
    begin
      i_host.acc(0, 1, 16'h0308, 4'h0, {16'h1000 + k[15:0], 16'h2000 + k[15:0]}, 0, q, ok);
      if (!ok)
        break;
    end
    tx_run = 1'b1;
    chk({31'h0, k == 20}, 32'h1);
    repeat (300) @(negedge clk);
    for (int j = 0; j < k; j++)
      chk({txq[2*j+1], txq[2*j]}, {16'h1000 + j[15:0], 16'h2000 + j[15:0]});
    txq.delete();
    run(0, 1, 16'h0000, 4'h0, 32'h7777_6666, 1);
    repeat (20) @(negedge clk);
    chk({txq[1], txq[0]}, 32'h7777_6666);
    summarize();
  end
endmodule // tb
